/* cirq_consts.svh */
// Constants for the coprocessor raw status and software interrupt block
`ifndef CIRQ_CONSTS_SVH
`define CIRQ_CONSTS_SVH

`define CIRQ_OFS_RAW0       32'h1014_0804
`define CIRQ_OFS_RAW1       32'h1014_0808
`define CIRQ_OFS_SET0       32'h1014_080c
`define CIRQ_OFS_SET1       32'h1014_0810
`define CIRQ_OFS_CLR0       32'h1014_0814
`define CIRQ_OFS_CLR1       32'h1014_0818

`define CIRQ_RST_VAL        32'h0000_0000
`define CIRQ_ZERO_WORD      32'h0000_0000
`define CIRQ_SRC_COUNT      64
`define CIRQ_VEC_SLOTS      16

`define CIRQ_G0_RSV_MASK    32'h10dc_4400
`define CIRQ_G1_RSV_MASK    32'h7f00_0000
`define CIRQ_G1_RSV_BITS    7'h00
`define CIRQ_G0_PIN_W       30
`define CIRQ_G1_PIN_W       25
`define CIRQ_RAW_LAT        3

`define CIRQ_B0_ADC         31
`define CIRQ_B0_ENCODER     30
`define CIRQ_B0_PWM         29
`define CIRQ_B0_DMA         27
`define CIRQ_B0_SYS_ERR     26
`define CIRQ_B0_PHY         25
`define CIRQ_B0_HOST_SOFT   24
`define CIRQ_B0_MOTION      21
`define CIRQ_B0_COMM        17
`define CIRQ_B0_GPIO        16
`define CIRQ_B0_HOST_IF     15
`define CIRQ_B0_I2C         13
`define CIRQ_B0_SPI         12
`define CIRQ_B0_USB         11
`define CIRQ_B0_UART1       9
`define CIRQ_B0_UART0       8
`define CIRQ_B0_WDOG        7
`define CIRQ_B0_EXT7        6
`define CIRQ_B0_SYSTIME     5
`define CIRQ_B0_TIMER2      4
`define CIRQ_B0_GPTIMER     3
`define CIRQ_B0_TIMER1      2
`define CIRQ_B0_TIMER0      1
`define CIRQ_B0_PURE_SOFT   0
`define CIRQ_B1_FAULT       31

`define CIRQ_MOTION_HI      15
`define CIRQ_MOTION_LO      12
`define CIRQ_COMM_HI        11
`define CIRQ_COMM_LO        0

`endif

/* cirq_pkg.sv */
// Types shared by the coprocessor raw and software interrupt block
package cirq_pkg;
  typedef logic [31:0] cirq_word_t;
  typedef enum {
    CIRQ_REG_NONE,
    CIRQ_REG_RAW0,
    CIRQ_REG_RAW1,
    CIRQ_REG_SET0,
    CIRQ_REG_SET1,
    CIRQ_REG_CLR0,
    CIRQ_REG_CLR1
  } cirq_reg_t;
endpackage

/* cirq_soft_if.sv */
// Set, clear and state lines between the register front end and one software bank
interface cirq_soft_if;
  import cirq_pkg::*;
  cirq_word_t setMask;
  cirq_word_t clrMask;
  cirq_word_t softState;
  modport ctrl (output setMask, output clrMask, input softState);
  modport bank (input setMask, input clrMask, output softState);
endinterface

/* cirq_sync_bank.sv */
// Two-flop synchronisers for interrupt lines from other clock domains
module cirq_sync_bank
  import cirq_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (rst) begin
          stage1_r[i] <= 1'b0;
          stage2_r[i] <= 1'b0;
        end else begin
          stage1_r[i] <= asyncIn[i];
          stage2_r[i] <= stage1_r[i];
        end
      end
    end
  endgenerate

  assign syncOut = stage2_r;
endmodule

/* cirq_soft_bank.sv */
// One group of 32 software interrupt bits with write-one set and clear
`include "cirq_consts.svh"
module cirq_soft_bank
  import cirq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  cirq_soft_if.bank port
);
  cirq_word_t soft_r;
  cirq_word_t soft_nxt;

  // Zero bits in either mask leave the bit alone; set wins over clear
  always_comb begin
    soft_nxt = (soft_r & ~port.clrMask) | port.setMask;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      soft_r <= `CIRQ_RST_VAL;
    end else begin
      soft_r <= soft_nxt;
    end
  end

  assign port.softState = soft_r;
endmodule

/* cirq_top.sv */
// Raw interrupt status and software interrupt registers of the coprocessor controller
// Behaviour
// - Group one raw status mirrors its 25 synchronised source lines, bits 30..24 read zero; read only.
// - Writing one to a set register bit asserts that software bit.
// - Writing zero to set or clear register bits changes nothing.
// - Set and clear registers read back the current software bits.
// - Writing one to a clear register bit deasserts that software bit.
// - Group zero bits 31,30,29,27,26: ADC, encoder, PWM, DMA, system error.
// - Group zero bit 25 PHY; bit 24 host to coprocessor software interrupt.
// - Bit 21 is lines 15..12 combined; bit 17 is lines 11..0 combined.
// - Group zero bits 28,23,22,20,19,18,14,10 have no source, read zero.
// - Bit 16 ORs general inputs 0..6; bit 6 is external input 7.
// - Bit 15 host interface, 13 I2C, 12 both SPI, 11 USB.
// - Bits 9 and 8 are the UARTs; bit 7 the coprocessor watchdog.
// - Bit 5 seconds compare; bits 4, 2, 1 coprocessor timers 2, 1, 0.
// - Bit 3 ORs both general timers from the coprocessor pending register.
// - Group zero bit 0 is purely software, no hardware source.
// - Group one: ADCs, encoder events, capture units, encoder markers, PWM, SPI, general timers, GPIO, data fault.
// - Software bits are ORed with raw hardware sources before selection.
// - Sixty-four selectable sources are presented for the vector slots.
`include "cirq_consts.svh"
module cirq_top
  import cirq_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [1:0]  adcIrq,
  input  wire logic [1:0]  encoderEvent,
  input  wire logic [3:0]  captureUnit,
  input  wire logic [1:0]  encoderMarker,
  input  wire logic        mpwmFailure,
  input  wire logic [1:0]  pwmIrq,
  input  wire logic [1:0]  spiIrq,
  input  wire logic [1:0]  gpTimerPending,
  input  wire logic [6:0]  gpioIrq,
  input  wire logic        dataFaultA,
  input  wire logic        dmaIrq,
  input  wire logic        systemStateError,
  input  wire logic        phyIrq,
  input  wire logic [15:0] commProcIrqLines,
  input  wire logic        hostIfaceIrq,
  input  wire logic        i2cIrq,
  input  wire logic        usbIrq,
  input  wire logic [1:0]  uartIrq,
  input  wire logic        coprocWatchdog,
  input  wire logic        extInput7Irq,
  input  wire logic        systimeSecIrq,
  input  wire logic [2:0]  coprocTimerIrq,
  output logic      [63:0] srcVec
);
  logic [`CIRQ_G1_PIN_W-1:0] pins1Sync;
  logic [`CIRQ_G0_PIN_W-1:0] pins0Sync;

  logic [1:0]  adcS;
  logic [1:0]  encS;
  logic [3:0]  capS;
  logic [1:0]  markerS;
  logic        mpwmFailS;
  logic [1:0]  pwmS;
  logic [1:0]  spiS;
  logic [1:0]  gptS;
  logic [6:0]  gpioS;
  logic        faultS;
  logic        dmaS;
  logic        sysErrS;
  logic        phyS;
  logic [15:0] commS;
  logic        hostIfS;
  logic        i2cS;
  logic        usbS;
  logic [1:0]  uartS;
  logic        wdogS;
  logic        ext7S;
  logic        systimeS;
  logic [2:0]  timerS;

  cirq_word_t  hw0Word;
  cirq_word_t  hw1Word;
  cirq_word_t  wMask;
  cirq_reg_t   regSel;
  logic        commit;

  cirq_word_t  raw0_r;
  cirq_word_t  raw0_nxt;
  cirq_word_t  raw1_r;
  cirq_word_t  raw1_nxt;
  logic [63:0] srcVec_r;
  logic [63:0] srcVec_nxt;
  cirq_word_t  readData_r;
  cirq_word_t  readData_nxt;
  logic        waitReq_r;
  logic        waitReq_nxt;

  cirq_soft_if soft0If ();
  cirq_soft_if soft1If ();

  // Source lines come from other clock domains, so every one is synchronised
  cirq_sync_bank #(
    .WIDTH (`CIRQ_G1_PIN_W)
  ) u_sync1 (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  ({dataFaultA, gpioIrq, gpTimerPending, spiIrq, mpwmFailure, pwmIrq,
                encoderMarker, captureUnit, encoderEvent, adcIrq}),
    .syncOut  (pins1Sync)
  );

  cirq_sync_bank #(
    .WIDTH (`CIRQ_G0_PIN_W)
  ) u_sync0 (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  ({dmaIrq, systemStateError, phyIrq, commProcIrqLines, hostIfaceIrq,
                i2cIrq, usbIrq, uartIrq, coprocWatchdog, extInput7Irq,
                systimeSecIrq, coprocTimerIrq}),
    .syncOut  (pins0Sync)
  );

  assign {faultS, gpioS, gptS, spiS, mpwmFailS, pwmS, markerS, capS, encS, adcS} =
    pins1Sync;
  assign {dmaS, sysErrS, phyS, commS, hostIfS, i2cS, usbS, uartS, wdogS, ext7S,
          systimeS, timerS} = pins0Sync;

  // Group one keeps the line order of its sources; the reserved field is tied low
  assign hw1Word = {faultS, `CIRQ_G1_RSV_BITS, gpioS, gptS, spiS, mpwmFailS, pwmS,
                    markerS, capS, encS, adcS};

  // Group zero merges several lines per bit; unlisted positions stay zero
  always_comb begin
    hw0Word = `CIRQ_ZERO_WORD;
    hw0Word[`CIRQ_B0_ADC]      = |adcS;
    hw0Word[`CIRQ_B0_ENCODER]  = |{encS, capS, markerS};
    hw0Word[`CIRQ_B0_PWM]      = |{pwmS, mpwmFailS};
    hw0Word[`CIRQ_B0_DMA]      = dmaS;
    hw0Word[`CIRQ_B0_SYS_ERR]  = sysErrS;
    hw0Word[`CIRQ_B0_PHY]      = phyS;
    // Host to coprocessor bit is left to software alone
    hw0Word[`CIRQ_B0_HOST_SOFT] = 1'b0;
    hw0Word[`CIRQ_B0_MOTION]   = |commS[`CIRQ_MOTION_HI:`CIRQ_MOTION_LO];
    hw0Word[`CIRQ_B0_COMM]     = |commS[`CIRQ_COMM_HI:`CIRQ_COMM_LO];
    hw0Word[`CIRQ_B0_GPIO]     = |gpioS;
    hw0Word[`CIRQ_B0_EXT7]     = ext7S;
    hw0Word[`CIRQ_B0_HOST_IF]  = hostIfS;
    hw0Word[`CIRQ_B0_I2C]      = i2cS;
    hw0Word[`CIRQ_B0_SPI]      = |spiS;
    hw0Word[`CIRQ_B0_USB]      = usbS;
    hw0Word[`CIRQ_B0_UART1]    = uartS[1];
    hw0Word[`CIRQ_B0_UART0]    = uartS[0];
    hw0Word[`CIRQ_B0_WDOG]     = wdogS;
    hw0Word[`CIRQ_B0_SYSTIME]  = systimeS;
    hw0Word[`CIRQ_B0_TIMER2]   = timerS[2];
    hw0Word[`CIRQ_B0_TIMER1]   = timerS[1];
    hw0Word[`CIRQ_B0_TIMER0]   = timerS[0];
    // Pending lines are the coprocessor's own copy, not the host's
    hw0Word[`CIRQ_B0_GPTIMER]  = |gptS;
  end

  // Address decode on full byte addresses
  always_comb begin
    unique case (avs_address)
      `CIRQ_OFS_RAW0: regSel = CIRQ_REG_RAW0;
      `CIRQ_OFS_RAW1: regSel = CIRQ_REG_RAW1;
      `CIRQ_OFS_SET0: regSel = CIRQ_REG_SET0;
      `CIRQ_OFS_SET1: regSel = CIRQ_REG_SET1;
      `CIRQ_OFS_CLR0: regSel = CIRQ_REG_CLR0;
      `CIRQ_OFS_CLR1: regSel = CIRQ_REG_CLR1;
      default:        regSel = CIRQ_REG_NONE;
    endcase
  end

  // Disabled byte lanes write zeros, which leave the software bits untouched
  assign wMask = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign commit = avs_write && !waitReq_r;

  // Raw status ignores writes; only set and clear addresses reach the banks
  assign soft0If.setMask = (commit && regSel == CIRQ_REG_SET0) ? wMask
                                                                : `CIRQ_ZERO_WORD;
  assign soft1If.setMask = (commit && regSel == CIRQ_REG_SET1) ? wMask
                                                                : `CIRQ_ZERO_WORD;
  assign soft0If.clrMask = (commit && regSel == CIRQ_REG_CLR0) ? wMask
                                                                : `CIRQ_ZERO_WORD;
  assign soft1If.clrMask = (commit && regSel == CIRQ_REG_CLR1) ? wMask
                                                                : `CIRQ_ZERO_WORD;

  cirq_soft_bank u_soft0 (
    .core_clk (core_clk),
    .rst      (rst),
    .port     (soft0If.bank)
  );

  cirq_soft_bank u_soft1 (
    .core_clk (core_clk),
    .rst      (rst),
    .port     (soft1If.bank)
  );

  // One wait cycle per access gives the read mux a full clock
  always_comb begin
    waitReq_nxt  = 1'b1;
    readData_nxt = readData_r;
    if ((avs_read || avs_write) && waitReq_r) begin
      waitReq_nxt = 1'b0;
    end
    if (avs_read && waitReq_r) begin
      unique case (regSel)
        CIRQ_REG_RAW0: readData_nxt = raw0_r;
        CIRQ_REG_RAW1: readData_nxt = raw1_r;
        CIRQ_REG_SET0: readData_nxt = soft0If.softState;
        CIRQ_REG_CLR0: readData_nxt = soft0If.softState;
        CIRQ_REG_SET1: readData_nxt = soft1If.softState;
        CIRQ_REG_CLR1: readData_nxt = soft1If.softState;
        CIRQ_REG_NONE: readData_nxt = `CIRQ_ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      waitReq_r  <= 1'b1;
      readData_r <= `CIRQ_ZERO_WORD;
    end else begin
      waitReq_r  <= waitReq_nxt;
      readData_r <= readData_nxt;
    end
  end

  // Raw status and the combined source vector
  always_comb begin
    raw0_nxt   = hw0Word;
    raw1_nxt   = hw1Word;
    // Software bits join before selection so every source can be forced
    srcVec_nxt = {raw1_r | soft1If.softState, raw0_r | soft0If.softState};
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      raw0_r   <= `CIRQ_RST_VAL;
      raw1_r   <= `CIRQ_RST_VAL;
      srcVec_r <= {`CIRQ_RST_VAL, `CIRQ_RST_VAL};
    end else begin
      raw0_r   <= raw0_nxt;
      raw1_r   <= raw1_nxt;
      srcVec_r <= srcVec_nxt;
    end
  end

  assign avs_readdata    = readData_r;
  assign avs_waitrequest = waitReq_r;
  assign srcVec          = srcVec_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_req_pending;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_ack_once;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_ack_timing: assert property (s_req_pending |=> s_ack_once)
    else $error("Bus request not answered after one wait cycle");

  a_set0_bits: assert property (
    (commit && regSel == CIRQ_REG_SET0) |=>
      ((soft0If.softState & $past(wMask)) == $past(wMask)))
    else $error("Set write did not assert software bits");

  a_clr1_bits: assert property (
    (commit && regSel == CIRQ_REG_CLR1) |=>
      ((soft1If.softState & $past(wMask)) == `CIRQ_ZERO_WORD))
    else $error("Clear write did not deassert software bits");

  a_zero_write_hold: assert property (
    (commit && regSel == CIRQ_REG_SET1) |=>
      ((soft1If.softState & ~$past(wMask)) ==
       ($past(soft1If.softState) & ~$past(wMask))))
    else $error("Zero bits of a set write changed state");

  a_read_soft_live: assert property (
    (avs_read && !avs_waitrequest && regSel == CIRQ_REG_CLR0) |->
      (avs_readdata == soft0If.softState))
    else $error("Clear register read does not show software state");

  a_raw1_pin_lat: assert property (
    !$past(rst, `CIRQ_RAW_LAT) |->
      (raw1_r[`CIRQ_B1_FAULT] == $past(dataFaultA, `CIRQ_RAW_LAT)))
    else $error("Group one raw bit does not follow its line");

  a_adc_or_lat: assert property (
    !$past(rst, `CIRQ_RAW_LAT) |->
      (raw0_r[`CIRQ_B0_ADC] == |$past(adcIrq, `CIRQ_RAW_LAT)))
    else $error("Group zero ADC bit is not the OR of both ADCs");

  a_reserved_zero: assert property (
    ((raw0_r & `CIRQ_G0_RSV_MASK) == `CIRQ_ZERO_WORD) &&
    (raw0_r[`CIRQ_B0_PURE_SOFT] == 1'b0) && (raw0_r[`CIRQ_B0_HOST_SOFT] == 1'b0))
    else $error("Reserved or software-only raw bit is set");

  a_soft_merge: assert property (
    (commit && regSel == CIRQ_REG_SET0) |=> ##1
      ((srcVec[31:0] & $past(wMask, 2)) == $past(wMask, 2)))
    else $error("Software set did not reach the source vector");

  a_soft_reset_zero: assert property (
    $past(rst) |-> (soft0If.softState == `CIRQ_ZERO_WORD &&
                    soft1If.softState == `CIRQ_ZERO_WORD && raw1_r == `CIRQ_ZERO_WORD))
    else $error("State not zero after reset");

  a_unmapped_zero: assert property (
    (avs_read && !avs_waitrequest && regSel == CIRQ_REG_NONE) |->
      (avs_readdata == `CIRQ_ZERO_WORD))
    else $error("Unmapped read returned nonzero data");

  a_clr0_bits: assert property (
    (commit && regSel == CIRQ_REG_CLR0) |=>
      ((soft0If.softState & $past(wMask)) == `CIRQ_ZERO_WORD))
    else $error("Group zero clear did not deassert software bits");

  a_set1_bits: assert property (
    (commit && regSel == CIRQ_REG_SET1) |=>
      ((soft1If.softState & $past(wMask)) == $past(wMask)))
    else $error("Group one set did not assert software bits");

  // A raw status write must not leak into either software bank
  a_raw_write_none: assert property (
    (commit && (regSel == CIRQ_REG_RAW0 || regSel == CIRQ_REG_RAW1)) |=>
      ($stable(soft0If.softState) && $stable(soft1If.softState)))
    else $error("Raw status write changed software state");

  a_raw1_read_data: assert property (
    (avs_read && !avs_waitrequest && regSel == CIRQ_REG_RAW1) |->
      (avs_readdata == $past(raw1_r)))
    else $error("Group one raw read does not show raw status");

  a_motion_or_lat: assert property (
    !$past(rst, `CIRQ_RAW_LAT) |->
      (raw0_r[`CIRQ_B0_MOTION] ==
       |$past(commProcIrqLines[`CIRQ_MOTION_HI:`CIRQ_MOTION_LO], `CIRQ_RAW_LAT)))
    else $error("Motion channel bit is not the OR of its lines");

  a_g1_rsv_zero: assert property (
    (raw1_r & `CIRQ_G1_RSV_MASK) == `CIRQ_ZERO_WORD)
    else $error("Group one reserved raw bit is set");
endmodule

/* cirq_tb_top.sv */
// Self-checking bench for the coprocessor raw status and software interrupt block
`include "cirq_consts.svh"
module cirq_tb_top
  import cirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk;
  logic        rst;
  logic [31:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [63:0] srcVec;
  logic [54:0] pins;
  int          n_fail;
  int          n_compared;

  // Raw group zero bit for each source pin (pin order as wired below); 255 means none
  byte unsigned r0Bit [55] = '{31, 31, 30, 30, 30, 30, 30, 30, 30, 30, 29, 29, 29, 12, 12,
    3, 3, 16, 16, 16, 16, 16, 16, 16, 255, 27, 26, 25, 17, 17, 17, 17, 17, 17, 17, 17, 17,
    17, 17, 17, 21, 21, 21, 21, 15, 13, 11, 8, 9, 7, 6, 5, 1, 2, 4};
  logic [31:0] regAddr [6] = '{`CIRQ_OFS_RAW0, `CIRQ_OFS_RAW1, `CIRQ_OFS_SET0,
    `CIRQ_OFS_SET1, `CIRQ_OFS_CLR0, `CIRQ_OFS_CLR1};

  always #2 core_clk = ~core_clk;

  cirq_top cirq_top_i (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .adcIrq(pins[1:0]), .encoderEvent(pins[3:2]), .captureUnit(pins[7:4]),
    .encoderMarker(pins[9:8]), .pwmIrq(pins[11:10]), .mpwmFailure(pins[12]),
    .spiIrq(pins[14:13]), .gpTimerPending(pins[16:15]), .gpioIrq(pins[23:17]),
    .dataFaultA(pins[24]), .dmaIrq(pins[25]), .systemStateError(pins[26]),
    .phyIrq(pins[27]), .commProcIrqLines(pins[43:28]), .hostIfaceIrq(pins[44]),
    .i2cIrq(pins[45]), .usbIrq(pins[46]), .uartIrq(pins[48:47]),
    .coprocWatchdog(pins[49]), .extInput7Irq(pins[50]), .systimeSecIrq(pins[51]),
    .coprocTimerIrq(pins[54:52]), .srcVec(srcVec));

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon access; the request stands until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [31:0] addr, input cirq_word_t wdata,
                     input logic [3:0] be, output cirq_word_t rdata);
    int k;
    @(posedge core_clk);
    avs_address    <= addr;
    avs_writedata  <= wdata;
    avs_byteenable <= be;
    avs_read       <= ~wr;
    avs_write      <= wr;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rdata = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (k == 20) begin
      n_fail++;
      $display("MISMATCH waitrequest expected 0 seen 1");
      end_sim();
    end
  endtask

  task automatic wr(input logic [31:0] addr, input cirq_word_t d, input logic [3:0] be);
    cirq_word_t unused;
    bus(1'b1, addr, d, be, unused);
  endtask

  task automatic rd(input logic [31:0] addr, input string what, input cirq_word_t exp);
    cirq_word_t v;
    bus(1'b0, addr, 32'h0, 4'hf, v);
    check(what, {32'h0, v}, {32'h0, exp});
  endtask

  // Pins pass two sync flops and a register, srcVec one more; five edges covers both
  task automatic settle();
    repeat (5) @(posedge core_clk);
  endtask

  initial begin
    cirq_word_t exp0;
    cirq_word_t exp1;
    core_clk       = 1'b0;
    rst            = 1'b1;
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = '0;
    avs_byteenable = 4'hf;
    pins           = '0;
    n_fail         = 0;
    n_compared     = 0;
    repeat (20) @(posedge core_clk);
    check("srcVec in reset", srcVec, 64'h0);
    check("waitrequest in reset", {63'h0, avs_waitrequest}, 64'h1);
    rst <= 1'b0;
    for (int a = 0; a < 6; a++) begin
      rd(regAddr[a], "reset value", 32'h0);
    end

    // One source pin at a time: each must land on its documented bit only
    for (int i = 0; i < 55; i++) begin
      exp0 = (r0Bit[i] == 8'hff) ? 32'h0 : (32'h1 << r0Bit[i]);
      exp1 = (i < 24) ? (32'h1 << i) : ((i == 24) ? 32'h8000_0000 : 32'h0);
      @(posedge core_clk);
      pins <= 55'h1 << i;
      settle();
      check("srcVec per pin", srcVec, {exp1, exp0});
      rd(`CIRQ_OFS_RAW0, "raw0 per pin", exp0);
      rd(`CIRQ_OFS_RAW1, "raw1 per pin", exp1);
      @(posedge core_clk);
      pins <= '0;
      settle();
    end

    // Every pin high: reserved and software-only positions stay clear
    @(posedge core_clk);
    pins <= '1;
    settle();
    rd(`CIRQ_OFS_RAW0, "raw0 all", ~(`CIRQ_G0_RSV_MASK | 32'h0100_0001));
    rd(`CIRQ_OFS_RAW1, "raw1 all", 32'h80ff_ffff);
    @(posedge core_clk);
    pins <= '0;
    settle();
    wr(`CIRQ_OFS_RAW1, 32'hffff_ffff, 4'hf);
    rd(`CIRQ_OFS_RAW1, "raw1 after write", 32'h0);
    rd(`CIRQ_OFS_SET1, "soft1 after raw write", 32'h0);

    // Software bits of group zero, back to back accesses
    wr(`CIRQ_OFS_SET0, 32'ha5a5_0f01, 4'hf);
    rd(`CIRQ_OFS_SET0, "set0 readback", 32'ha5a5_0f01);
    rd(`CIRQ_OFS_CLR0, "clr0 readback", 32'ha5a5_0f01);
    rd(`CIRQ_OFS_RAW0, "raw0 without soft", 32'h0);
    check("srcVec soft0", srcVec, {32'h0, 32'ha5a5_0f01});
    wr(`CIRQ_OFS_SET0, 32'h0, 4'hf);
    rd(`CIRQ_OFS_SET0, "set0 zero write", 32'ha5a5_0f01);
    wr(`CIRQ_OFS_CLR0, 32'h0, 4'hf);
    rd(`CIRQ_OFS_CLR0, "clr0 zero write", 32'ha5a5_0f01);
    wr(`CIRQ_OFS_CLR0, 32'h8001_0001, 4'hf);
    rd(`CIRQ_OFS_SET0, "clear0 partial", 32'h25a4_0f00);
    // Only the enabled byte lane may set bits
    wr(`CIRQ_OFS_SET0, 32'hffff_ffff, 4'b0010);
    rd(`CIRQ_OFS_SET0, "set0 one lane", 32'h25a4_ff00);

    // Group one, including the reserved positions that still store soft bits
    wr(`CIRQ_OFS_SET1, 32'hffff_ffff, 4'hf);
    rd(`CIRQ_OFS_CLR1, "clr1 readback", 32'hffff_ffff);
    wr(`CIRQ_OFS_CLR1, 32'h7f00_0000, 4'hf);
    rd(`CIRQ_OFS_SET1, "clear1 partial", 32'h80ff_ffff);
    check("srcVec both groups", srcVec, {32'h80ff_ffff, 32'h25a4_ff00});

    // Unmapped place: write ignored, read zero
    wr(32'h1014_0800, 32'hffff_ffff, 4'hf);
    rd(32'h1014_0800, "unmapped read", 32'h0);
    rd(`CIRQ_OFS_SET0, "soft0 after unmapped", 32'h25a4_ff00);

    // Reset in mid-run wipes the stored software state
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("srcVec mid reset", srcVec, 64'h0);
    rst <= 1'b0;
    rd(`CIRQ_OFS_SET0, "soft0 after reset", 32'h0);
    rd(`CIRQ_OFS_SET1, "soft1 after reset", 32'h0);
    end_sim();
  end
endmodule
